// [hw/rfa_pkg.sv]
// rfa_pkg: constants and types for the readout fragment assembler
// assumes one system clock; register offsets are byte addresses
`default_nettype none
package rfa_pkg;
   localparam int unsigned ADDR_W = 8;
   // register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_VERSION = 8'h04;
   localparam logic [7:0] REG_SUBDET = 8'h08;
   localparam logic [7:0] REG_RUN = 8'h0C;
   localparam logic [7:0] REG_EVTYPE = 8'h10;
   localparam logic [7:0] REG_ORBIT_WRAP = 8'h14;
   localparam logic [7:0] REG_PULSE = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1C;
   localparam logic [7:0] REG_ORBIT = 8'h20;
   // control register fields
   localparam int unsigned CTRL_EN_LSB = 0;
   localparam int unsigned CTRL_DTYPE_BIT = 7;
   localparam int unsigned CTRL_CRATE_LSB = 8;
   // pulse register bits
   localparam int unsigned PULSE_ORBIT_RST = 0;
   localparam int unsigned PULSE_TIMING_RST = 1;
   localparam int unsigned PULSE_QUEUE_RST = 2;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] VERSION_RST = 32'h0000_0000;
   localparam logic [7:0] SUBDET_RST = 8'h71;
   localparam logic [31:0] ORBIT_WRAP_RST = 32'hFFFF_FFFF;
   // subsystem identifiers
   localparam logic [7:0] SUBDET_PPM = 8'h71;
   localparam logic [7:0] SUBDET_CP_EVT = 8'h72;
   localparam logic [7:0] SUBDET_CP_REG = 8'h73;
   localparam logic [7:0] SUBDET_JEP_EVT = 8'h74;
   localparam logic [7:0] SUBDET_JEP_REG = 8'h75;
   // fragment words
   localparam logic [31:0] WORD_BOF = 32'hB0F0_0000;
   localparam logic [31:0] WORD_EOF = 32'hE0F0_0000;
   localparam logic [31:0] WORD_HDR_MARK = 32'hEE12_34EE;
   localparam logic [31:0] WORD_HDR_SIZE = 32'h0000_0009;
   localparam logic [31:0] WORD_STAT_CNT = 32'h0000_0002;
   localparam logic [31:0] WORD_STAT_POS = 32'h0000_0001;
   localparam logic [3:0] HDR_LAST = 4'h8;
   localparam logic [3:0] TRL_LAST = 4'h4;
   typedef enum logic [2:0] {
      ST_IDLE, ST_BOF, ST_HDR, ST_PAY, ST_TRL, ST_EOF
   } rfa_state_t;
endpackage
`default_nettype wire

// [hw/rfa_assembler.sv]
// rfa_assembler: builds readout fragments for up to four serial links
// assumes link and queue inputs are synchronous to clk_i; upstream
// payload sources hold data until taken
`default_nettype none
// What this block does
// - each trigger yields one fragment per enabled link, links run independently
// - one word per cycle per link, gaps only while link full, one cycle after full in payload, or payload word not valid
// - control word, nine header words, payload and trailer, control word
// - opening control word is B0F00000 with control flag
// - header starts with EE1234EE then header size word
// - version word copied whole from version register
// - module id is type bit, zero, link number, crate number
// - subsystem id codes 71 to 75 per source type
// - run word: run type high byte, 24-bit run number low
// - event id word: reset count high byte, event number low 24 bits
// - crossing number word then trigger type word
// - last header word: orbit queue head high, event type low half
// - orbit counter counts bunch resets, wraps to zero at wrap value
// - orbit reset or timing reset pulse clears orbit counter
// - queue reset pulse empties orbit queue
// - payload is user header then event data, passed through
// - trailer: two status words, count 2, payload word count
// - last trailer word is 1
// - closing control word is E0F00000
// - reset count increments on counter reset, clears on run load
// - queued header values taken when block available signalled
module rfa_assembler
   import rfa_pkg::*;
#(
   parameter int unsigned LINKS = 4,
   parameter int unsigned QDEPTH = 256
) (
   input wire logic clk_i, // system clock
   input wire logic resetn_i, // async reset, active low
   input wire logic [rfa_pkg::ADDR_W-1:0] addr_i, // register address
   input wire logic [31:0] wr_data_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [31:0] rd_data_o, // read data, cycle after strobe
   input wire logic l1a_i, // level-1 accept
   input wire logic bunch_counter_reset_i, // qualified bunch reset
   input wire logic counter_reset_i, // event counter reset command
   input wire logic block_ready_i, // complete data block available
   input wire logic [23:0] level1_event_number_i, // queued event number
   input wire logic [11:0] crossing_number_i, // queued crossing number
   input wire logic [7:0] trigger_type_i, // queued trigger type
   output logic frag_busy_o, // some link still sending
   input wire logic [LINKS-1:0] pay_valid_i, // payload word valid
   input wire logic [LINKS-1:0] pay_last_i, // last payload word
   input wire logic [32*LINKS-1:0] pay_data_i, // payload words
   output logic [LINKS-1:0] pay_ready_o, // payload word taken
   input wire logic [64*LINKS-1:0] status_i, // two status words per link
   input wire logic [LINKS-1:0] link_full_i, // link full, hold off
   output logic [LINKS-1:0] link_valid_o, // link word strobe
   output logic [LINKS-1:0] link_ctrl_o, // word is a control word
   output logic [32*LINKS-1:0] link_data_o // link words
);
   import rfa_pkg::*;
   localparam int unsigned QW = $clog2(QDEPTH);

   logic [31:0] ctrl, version, run, evtype, orbit_wrap, orbit;
   logic [7:0] subdet, reset_count;
   logic [15:0] qmem [QDEPTH];
   logic [QW-1:0] qwp, qrp;
   logic [QW:0] qlevel;
   logic q_overflow;
   logic [31:0] h_evid, h_orbtype;
   logic [11:0] h_bcn;
   logic [7:0] h_ttype;
   logic [LINKS-1:0] busy_n;

   // register decode
   wire wr_ctrl = wr_i && addr_i == REG_CTRL;
   wire wr_version = wr_i && addr_i == REG_VERSION;
   wire wr_subdet = wr_i && addr_i == REG_SUBDET;
   wire wr_run = wr_i && addr_i == REG_RUN;
   wire wr_evtype = wr_i && addr_i == REG_EVTYPE;
   wire wr_wrap = wr_i && addr_i == REG_ORBIT_WRAP;
   wire wr_pulse = wr_i && addr_i == REG_PULSE;
   wire orbit_clr = wr_pulse &&
      (wr_data_i[PULSE_ORBIT_RST] || wr_data_i[PULSE_TIMING_RST]);
   wire queue_clr = wr_pulse && wr_data_i[PULSE_QUEUE_RST];
   // orbit step, wrap compared on the incremented value
   wire [31:0] orbit_inc = orbit + 32'h0000_0001;
   wire orbit_wraps = orbit_inc == orbit_wrap;
   wire [31:0] next_orbit = orbit_wraps ? 32'h0000_0000 : orbit_inc;
   // a ready pulse while busy is dropped, not queued
   wire start = block_ready_i && !frag_busy_o;
   // orbit queue
   wire q_empty = qlevel == '0;
   wire q_full = qlevel == (QW+1)'(QDEPTH);
   wire q_push = l1a_i && !q_full;
   wire q_pop = start && !q_empty;
   // empty queue reads as orbit zero
   wire [15:0] q_head = q_empty ? 16'h0000 : qmem[qrp];
   // status: reset count, overflow, enabled links still running
   wire [LINKS-1:0] busy_en = ctrl[LINKS-1:0] & busy_n;
   wire [3:0] busy_4 = 4'(busy_en);
   wire [31:0] status_word = {16'h0000, reset_count, 3'b000, q_overflow, busy_4};
   // unmapped addresses read as zero
   wire [31:0] rd_mux =
      addr_i == REG_CTRL ? ctrl :
      addr_i == REG_VERSION ? version :
      addr_i == REG_SUBDET ? {24'h0000_00, subdet} :
      addr_i == REG_RUN ? run :
      addr_i == REG_EVTYPE ? evtype :
      addr_i == REG_ORBIT_WRAP ? orbit_wrap :
      addr_i == REG_STATUS ? status_word :
      addr_i == REG_ORBIT ? orbit : 32'h0000_0000;

   // software registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) ctrl <= CTRL_RST;
      else if (wr_ctrl) ctrl <= wr_data_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) version <= VERSION_RST;
      else if (wr_version) version <= wr_data_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) subdet <= SUBDET_RST;
      else if (wr_subdet) subdet <= wr_data_i[7:0];
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) run <= 32'h0000_0000;
      else if (wr_run) run <= wr_data_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) evtype <= 32'h0000_0000;
      else if (wr_evtype) evtype <= wr_data_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) orbit_wrap <= ORBIT_WRAP_RST;
      else if (wr_wrap) orbit_wrap <= wr_data_i;
   end

   // read data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) rd_data_o <= 32'h0000_0000;
      else rd_data_o <= rd_i ? rd_mux : 32'h0000_0000;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) reset_count <= 8'h00;
      else if (wr_run) reset_count <= 8'h00;
      else if (counter_reset_i) reset_count <= reset_count + 8'h01;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) orbit <= 32'h0000_0000;
      else if (orbit_clr) orbit <= 32'h0000_0000;
      else if (bunch_counter_reset_i) orbit <= next_orbit;
   end

   // orbit queue with flush
   // orbit low half stored per accept
   always_ff @(posedge clk_i) begin
      if (q_push) qmem[qwp] <= orbit[15:0];
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) qwp <= '0;
      else if (queue_clr) qwp <= '0;
      else if (q_push) qwp <= qwp + 1'b1;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) qrp <= '0;
      else if (queue_clr) qrp <= '0;
      else if (q_pop) qrp <= qrp + 1'b1;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) qlevel <= '0;
      else if (queue_clr) qlevel <= '0;
      else if (q_push && !q_pop) qlevel <= qlevel + 1'b1;
      else if (q_pop && !q_push) qlevel <= qlevel - 1'b1;
   end

   // a dropped push beats a flush in the same cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) q_overflow <= 1'b0;
      else if (l1a_i && q_full) q_overflow <= 1'b1;
      else if (queue_clr) q_overflow <= 1'b0;
   end

   // header values captured at block start
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) h_evid <= 32'h0000_0000;
      else if (start) h_evid <= {reset_count, level1_event_number_i};
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) h_bcn <= 12'h000;
      else if (start) h_bcn <= crossing_number_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) h_ttype <= 8'h00;
      else if (start) h_ttype <= trigger_type_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) h_orbtype <= 32'h0000_0000;
      else if (start) h_orbtype <= {q_head, evtype[15:0]};
   end

   // high while any link has work left
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) frag_busy_o <= 1'b0;
      else frag_busy_o <= |busy_n;
   end

   // one fragment engine per link, all sharing the latched header
   for (genvar g = 0; g < LINKS; g++) begin : g_link
      rfa_state_t st, next_st;
      logic [3:0] idx;
      logic [31:0] dcount, hdr_w, trl_w, word;
      wire adv = !link_full_i[g];
      wire take = pay_valid_i[g] && pay_ready_o[g];
      wire pay_end = take && pay_last_i[g];
      wire [31:0] pay_word = pay_data_i[32*g +: 32];
      // control words bracket each fragment
      wire st_ctrl = st == ST_BOF || st == ST_EOF;
      wire idx_end = (st == ST_HDR && idx == HDR_LAST) ||
         (st == ST_TRL && idx == TRL_LAST);
      wire [7:0] module_id = {ctrl[CTRL_DTYPE_BIT], 1'b0, 2'(g),
         ctrl[CTRL_CRATE_LSB +: 4]};
      // payload words leave only on a handshake
      wire emit = (st == ST_PAY) ? take : (st != ST_IDLE && adv);

      // header words
      // reserved bytes of header words are zero
      always_comb begin
         unique case (idx)
            4'h0: hdr_w = WORD_HDR_MARK;
            4'h1: hdr_w = WORD_HDR_SIZE;
            4'h2: hdr_w = version;
            4'h3: hdr_w = {8'h00, subdet, 8'h00, module_id};
            4'h4: hdr_w = run;
            4'h5: hdr_w = h_evid;
            4'h6: hdr_w = {20'h0000_0, h_bcn};
            4'h7: hdr_w = {24'h0000_00, h_ttype};
            default: hdr_w = h_orbtype;
         endcase
      end

      always_comb begin
         unique case (idx)
            4'h0: trl_w = status_i[64*g +: 32];
            4'h1: trl_w = status_i[64*g+32 +: 32];
            4'h2: trl_w = WORD_STAT_CNT;
            4'h3: trl_w = dcount;
            default: trl_w = WORD_STAT_POS;
         endcase
      end

      always_comb begin
         unique case (st)
            ST_BOF: word = WORD_BOF;
            ST_HDR: word = hdr_w;
            ST_PAY: word = pay_word;
            ST_TRL: word = trl_w;
            default: word = WORD_EOF;
         endcase
      end

      always_comb begin
         next_st = st;
         unique case (st)
            ST_IDLE: if (start && ctrl[CTRL_EN_LSB + g]) next_st = ST_BOF;
            ST_BOF: if (adv) next_st = ST_HDR;
            ST_HDR: if (adv && idx_end) next_st = ST_PAY;
            ST_PAY: if (take && pay_last_i[g]) next_st = ST_TRL;
            ST_TRL: if (adv && idx_end) next_st = ST_EOF;
            ST_EOF: if (adv) next_st = ST_IDLE;
         endcase
      end

      assign busy_n[g] = next_st != ST_IDLE;

      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) st <= ST_IDLE;
         else st <= next_st;
      end

      // index restarts on every state change
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) idx <= 4'h0;
         else if (next_st != st) idx <= 4'h0;
         else if (emit) idx <= idx + 4'h1;
      end

      // payload word count
      // cleared while the opening word waits
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) dcount <= 32'h0000_0000;
         else if (st == ST_BOF) dcount <= 32'h0000_0000;
         else if (st == ST_PAY && take) dcount <= dcount + 32'h0000_0001;
      end

      // one word per cycle when link not full
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            link_valid_o[g] <= 1'b0;
            link_ctrl_o[g] <= 1'b0;
         end else begin
            link_valid_o[g] <= emit;
            link_ctrl_o[g] <= emit && st_ctrl;
         end
      end

      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) link_data_o[32*g +: 32] <= 32'h0000_0000;
         else if (emit) link_data_o[32*g +: 32] <= word;
      end

      // one-word slack: ready lags link full by a cycle
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) pay_ready_o[g] <= 1'b0;
         else pay_ready_o[g] <= next_st == ST_PAY && adv && !pay_end;
      end
   end
endmodule // rfa_assembler
`default_nettype wire

// [verification/rfa_assembler_checker.sv]
// rfa_assembler_checker: port assertions on link 0
// assumes it is bound into rfa_assembler
`default_nettype none
module rfa_assembler_checker
   import rfa_pkg::*;
#(
   parameter int unsigned LINKS = 4
) (
   input wire logic clk_i, // clock
   input wire logic resetn_i, // reset, active low
   input wire logic block_ready_i, // start request
   input wire logic frag_busy_o, // fragment running
   input wire logic [LINKS-1:0] pay_ready_o, // payload taken
   input wire logic [LINKS-1:0] link_full_i, // hold off
   input wire logic [LINKS-1:0] link_valid_o, // word strobe
   input wire logic [LINKS-1:0] link_ctrl_o, // control flag
   input wire logic [32*LINKS-1:0] link_data_o // words
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [32:0] prev;
   wire logic v = link_valid_o[0];
   wire logic c = link_ctrl_o[0];
   wire logic [31:0] d = link_data_o[31:0];
   // previous word sent on link 0
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) prev <= '0;
      else if (v) prev <= {c, d};
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_ctrl_val; v && c |-> d == WORD_BOF || d == WORD_EOF; endproperty
   a_ctrl_val: assert property (p_ctrl_val) else $error("bad control word");
   property p_ctrl_only; c |-> v; endproperty
   a_ctrl_only: assert property (p_ctrl_only) else $error("control flag alone");
   property p_mark; v && prev == {1'b1, WORD_BOF} |-> !c && d == WORD_HDR_MARK; endproperty
   a_mark: assert property (p_mark) else $error("no marker after open");
   property p_size; v && prev == {1'b0, WORD_HDR_MARK} |-> d == WORD_HDR_SIZE; endproperty
   a_size: assert property (p_size) else $error("bad header size");
   property p_tail; v && c && d == WORD_EOF |-> prev == {1'b0, WORD_STAT_POS}; endproperty
   a_tail: assert property (p_tail) else $error("close not after position word");
   property p_eof_gap; v && c && d == WORD_EOF |=> !v; endproperty
   a_eof_gap: assert property (p_eof_gap) else $error("word right after close");
   property p_full; v && c |-> !$past(link_full_i[0]); endproperty
   a_full: assert property (p_full) else $error("control word while full");
   property p_start; $rose(frag_busy_o) |-> $past(block_ready_i); endproperty
   a_start: assert property (p_start) else $error("start without block ready");
   property p_ready; pay_ready_o[0] |-> frag_busy_o; endproperty
   a_ready: assert property (p_ready) else $error("payload ready while idle");
endmodule // rfa_assembler_checker
bind rfa_assembler rfa_assembler_checker #(.LINKS(LINKS)) rfa_assembler_checker_inst (
   .clk_i, .resetn_i, .block_ready_i, .frag_busy_o, .pay_ready_o, .link_full_i,
   .link_valid_o, .link_ctrl_o, .link_data_o);
`default_nettype wire

// [verification/rfa_link_card.sv]
// rfa_link_card: far-side link card, raises full by mode
// assumes one card per link, synchronous to clk_i
`default_nettype none
module rfa_link_card (
   input wire logic clk_i, // clock
   input wire logic resetn_i, // reset, active low
   input wire logic [1:0] mode_i, // 0 open, 1 after each word, 2 mostly full
   input wire logic valid_i, // word strobe
   output logic full_o // hold off
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= '0;
         full_o <= 1'b0;
      end else begin
         cnt <= cnt + 2'd1;
         full_o <= mode_i == 2'd2 ? cnt != 2'd0 : mode_i == 2'd1 && valid_i;
      end
   end
endmodule // rfa_link_card
`default_nettype wire

// [verification/test_rfa_assembler.sv]
// test_rfa_assembler: self-checking bench, two links
// assumes rfa_pkg, the link card and the checker are compiled first
`default_nettype none
module test_rfa_assembler;
   timeunit 1ns;
   timeprecision 1ns;
   import rfa_pkg::*;
   logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, rd_seen = 0, busy;
   logic [3:0] ev = '0;
   logic [7:0] addr_i = '0, tt = '0, cr = '0;
   logic [31:0] wr_data_i = '0, rd_data_o, o = '0, wv = ORBIT_WRAP_RST;
   logic [23:0] evn = '0;
   logic [11:0] bcn = '0;
   logic [1:0] pv = '0, pl = '0, prdy, lfull, lv, lc, m0 = '0, m1 = '0;
   logic [63:0] pd = '0, ld;
   logic [127:0] st = '0;
   logic [32:0] exq[2][$];
   logic [31:0] pq[2][$], exr[$];
   logic [15:0] oq[$];
   int err_total = 0, cmp_count = 0;
   initial forever #25 clk_i = ~clk_i;
   rfa_assembler #(.LINKS(2), .QDEPTH(8)) rfa_assembler_inst (.clk_i, .resetn_i, .addr_i,
      .wr_data_i, .wr_i, .rd_i, .rd_data_o, .l1a_i(ev[0]), .bunch_counter_reset_i(ev[1]),
      .counter_reset_i(ev[2]), .block_ready_i(ev[3]), .level1_event_number_i(evn),
      .crossing_number_i(bcn), .trigger_type_i(tt), .frag_busy_o(busy), .pay_valid_i(pv),
      .pay_last_i(pl), .pay_data_i(pd), .pay_ready_o(prdy), .status_i(st),
      .link_full_i(lfull), .link_valid_o(lv), .link_ctrl_o(lc), .link_data_o(ld));
   rfa_link_card rfa_link_card_inst[1:0] (.clk_i, .resetn_i, .mode_i({m1, m0}), .valid_i(lv),
      .full_o(lfull));
   task automatic chk(string n, logic [32:0] e, logic [32:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic bus(bit w, logic [7:0] a, logic [31:0] d);
      addr_i <= a; wr_data_i <= d; wr_i <= w; rd_i <= !w;
      if (!w) exr.push_back(d);
      @(posedge clk_i);
      wr_i <= 0; rd_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic pulse(int b);
      ev[b] <= 1;
      @(posedge clk_i);
      ev[b] <= 0;
      @(posedge clk_i);
   endtask
   task automatic ob();
      pulse(1);
      o = (o + 1 == wv) ? '0 : o + 1;
   endtask
   task automatic frag(logic [7:0] sd, logic [7:0] rt);
      logic [31:0] run, hw[9], tl[5];
      int n;
      run = {rt, 24'($urandom)};
      bus(1, REG_RUN, run);
      bus(1, REG_SUBDET, {24'h0, sd});
      cr = 0;
      repeat ($urandom_range(3)) begin pulse(2); cr++; end
      ob();
      pulse(0);
      oq.push_back(o[15:0]);
      evn <= 24'($urandom); bcn <= 12'($urandom); tt <= 8'($urandom);
      st <= {$urandom, $urandom, $urandom, $urandom};
      @(posedge clk_i);
      for (int l = 0; l < 2; l++) begin
         n = 1 + $urandom_range(2);
         hw = '{WORD_HDR_MARK, WORD_HDR_SIZE, 32'h0207_1A3C, {8'h0, sd, 8'h0, 2'b10, 2'(l), 4'h5},
            run, {cr, evn}, {20'h0, bcn}, {24'h0, tt}, {oq[0], 16'h5A3C}};
         exq[l].push_back({1'b1, WORD_BOF});
         foreach (hw[i]) exq[l].push_back({1'b0, hw[i]});
         repeat (n) begin pq[l].push_back($urandom); exq[l].push_back({1'b0, pq[l][$]}); end
         tl = '{st[64*l +: 32], st[64*l+32 +: 32], WORD_STAT_CNT, 32'(n), WORD_STAT_POS};
         foreach (tl[i]) exq[l].push_back({1'b0, tl[i]});
         exq[l].push_back({1'b1, WORD_EOF});
      end
      void'(oq.pop_front());
      pulse(3);
      for (n = 0; n < 400 && (busy !== 0 || exq[0].size() || exq[1].size()); n++) @(posedge clk_i);
      if (n == 400) begin err_total++; report_and_stop(); end
      $display("fragment subsystem %h done", sd);
   endtask
   // payload sources, one word per handshake
   always @(posedge clk_i) for (int l = 0; l < 2; l++) begin
      if (pv[l] && prdy[l]) void'(pq[l].pop_front());
      pv[l] <= pq[l].size() > 0;
      pl[l] <= pq[l].size() == 1;
      pd[32*l +: 32] <= pq[l].size() ? pq[l][0] : ~pd[32*l +: 32];
   end
   always @(posedge clk_i) rd_seen <= rd_i;
   always @(negedge clk_i) begin
      if (rd_seen) chk("rd_data_o", {1'b0, exr.pop_front()}, {1'b0, rd_data_o});
      for (int l = 0; l < 2; l++)
         if (lv[l]) chk("link word", exq[l].size() ? exq[l].pop_front() : 'x, {lc[l], ld[32*l +: 32]});
   end
   initial begin
      logic [7:0] sds[5] = '{SUBDET_PPM, SUBDET_CP_EVT, SUBDET_CP_REG, SUBDET_JEP_EVT, SUBDET_JEP_REG};
      logic [7:0] rts[5] = '{8'd0, 8'd1, 8'd2, 8'd15, 8'd0};
      void'($urandom(74480));
      repeat (12) @(posedge clk_i);
      resetn_i <= 1;
      @(posedge clk_i);
      bus(0, REG_CTRL, CTRL_RST);
      bus(0, REG_SUBDET, {24'h0, SUBDET_RST});
      bus(0, REG_ORBIT_WRAP, ORBIT_WRAP_RST);
      bus(0, 8'h40, 32'h0000_0000);
      $display("reset values done");
      bus(1, REG_ORBIT_WRAP, 32'h0000_0003);
      wv = 3;
      repeat (5) ob();
      bus(0, REG_ORBIT, o);
      bus(1, REG_PULSE, 32'h0000_0001);
      o = 0;
      bus(0, REG_ORBIT, o);
      ob();
      bus(1, REG_PULSE, 32'h0000_0002);
      o = 0;
      bus(0, REG_ORBIT, o);
      $display("orbit counter done");
      pulse(0);
      ob();
      pulse(2);
      pulse(2);
      repeat (9) pulse(0);
      bus(0, REG_STATUS, 32'h0000_0210);
      bus(1, REG_PULSE, 32'h0000_0004);
      bus(0, REG_STATUS, 32'h0000_0200);
      // version values arbitrary, minor top nibble 1
      bus(1, REG_VERSION, 32'h0207_1A3C);
      bus(1, REG_EVTYPE, 32'h9E61_5A3C);
      bus(1, REG_CTRL, 32'h0000_0583);
      for (int i = 0; i < 5; i++) begin
         m0 <= 2'(i % 3);
         m1 <= 2'((i + 1) % 3);
         frag(sds[i], rts[i]);
      end
      report_and_stop();
   end
endmodule // test_rfa_assembler
`default_nettype wire
